// *** src/ofdc_top.sv ***
`timescale 1ns/100ps
`include "ofdc_defines.svh"

// Notes on behaviour
// R01: Output is VCO divided by HS times LS
// R02: Feedback divider is 11.32 fixed point
// R03: High-speed divider is 11-bit integer
// R04: Odd ratios 5..33 get 50% duty
// R05: Low-speed divides by two to exponent
// R06: Exponents 6 and 7 act as 5
// R07: Host loads high-speed ratio 5..2046 only
// R08: Dual output, complementary or in phase
// R09: Host writes change frequency at run time
// R10: Small change glitchless, settles in 100us
// R11: Large change squelched, settles in 10ms
// R12: New set applied only as a whole
module ofdc_top
    import ofdc_pkg::*;
#(
    parameter int SMALL_CYC = `OFDC_SMALL_CYC,
    parameter int LARGE_CYC = `OFDC_LARGE_CYC
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Synthesized VCO clock
    input  wire logic        vco_clk,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Active feedback divider to synthesizer
    output logic [42:0]      feedback_divider,
    // Clock outputs
    output logic             clk_out_a,
    output logic             clk_out_b
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    ofdc_cfg_t   shadow_reg, shadow_next;
    ofdc_cfg_t   active_reg, active_next;
    logic        inv_reg, inv_next;
    logic        apply_reg, apply_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        ack_reg, ack_next;
    logic        req;
    ofdc_state_t state_reg, state_next;

    assign req = (avs_read | avs_write) & ~ack_reg;

    always_comb
    begin
        shadow_next = shadow_reg;
        inv_next    = inv_reg;
        apply_next  = 1'b0;
        rdata_next  = rdata_reg;
        ack_next    = req;
        if (req && avs_write)
        begin
            case (avs_address)
                `OFDC_OFF_FB_FRAC: shadow_next.fb_frac = avs_writedata;
                `OFDC_OFF_FB_INT:  shadow_next.fb_int  = avs_writedata[10:0];
                `OFDC_OFF_HS_DIV:  shadow_next.hs_div  = avs_writedata[10:0];
                `OFDC_OFF_CTRL:
                begin
                    shadow_next.ls_exp = avs_writedata[`OFDC_CTRL_LS_MSB:`OFDC_CTRL_LS_LSB];
                    inv_next           = avs_writedata[`OFDC_CTRL_INV_BIT];
                    apply_next         = avs_writedata[`OFDC_CTRL_APPLY_BIT]; // R12
                end
                default: ;
            endcase
        end
        if (req && avs_read)
        begin
            rdata_next = 32'h0000_0000;
            case (avs_address)
                `OFDC_OFF_FB_FRAC: rdata_next = shadow_reg.fb_frac;
                `OFDC_OFF_FB_INT:  rdata_next[10:0] = shadow_reg.fb_int;
                `OFDC_OFF_HS_DIV:  rdata_next[10:0] = shadow_reg.hs_div;
                `OFDC_OFF_CTRL:
                begin
                    rdata_next[`OFDC_CTRL_LS_MSB:`OFDC_CTRL_LS_LSB] = shadow_reg.ls_exp;
                    rdata_next[`OFDC_CTRL_INV_BIT]     = inv_reg;
                    rdata_next[`OFDC_CTRL_SQUELCH_BIT] = (state_reg == OFDC_MUTE);
                    rdata_next[`OFDC_CTRL_BUSY_BIT]    = (state_reg != OFDC_RUN);
                    rdata_next[`OFDC_CTRL_PEND_BIT]    = (shadow_reg != active_reg);
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Change sequencer
    // ------------------------------------------------------------------
    logic [31:0] timer_reg, timer_next;
    logic [43:0] fb_delta;
    logic        large_change;

    // Large change: any output divider change, or feedback beyond 950 ppm
    always_comb
    begin
        fb_delta = (shadow_reg.fb_int > active_reg.fb_int ||
                    ({shadow_reg.fb_int, shadow_reg.fb_frac} >=
                     {active_reg.fb_int, active_reg.fb_frac}))
                 ? {1'b0, shadow_reg.fb_int, shadow_reg.fb_frac} -
                   {1'b0, active_reg.fb_int, active_reg.fb_frac}
                 : {1'b0, active_reg.fb_int, active_reg.fb_frac} -
                   {1'b0, shadow_reg.fb_int, shadow_reg.fb_frac};
        // 950 ppm approximated as 1/1024 of the active value
        large_change = (shadow_reg.hs_div != active_reg.hs_div) ||
                       (shadow_reg.ls_exp != active_reg.ls_exp) ||
                       (fb_delta > {11'h000, active_reg.fb_int, active_reg.fb_frac[31:10]});
    end

    always_comb
    begin
        state_next  = state_reg;
        timer_next  = timer_reg;
        active_next = active_reg;
        case (state_reg)
            OFDC_RUN:
                if (apply_reg)
                begin
                    active_next = shadow_reg; // R09 R12
                    if (large_change)
                    begin
                        state_next = OFDC_MUTE; // R11
                        timer_next = 32'(LARGE_CYC - 1);
                    end
                    else
                    begin
                        state_next = OFDC_SETTLE; // R10
                        timer_next = 32'(SMALL_CYC - 1);
                    end
                end
            OFDC_SETTLE, OFDC_MUTE:
                if (timer_reg == 32'h0000_0000)
                    state_next = OFDC_RUN;
                else
                    timer_next = timer_reg - 32'h0000_0001;
            default: state_next = OFDC_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            shadow_reg <= '{`OFDC_RST_FB_INT, `OFDC_RST_FB_FRAC, `OFDC_RST_HS_DIV, `OFDC_RST_LS_EXP};
            active_reg <= '{`OFDC_RST_FB_INT, `OFDC_RST_FB_FRAC, `OFDC_RST_HS_DIV, `OFDC_RST_LS_EXP};
            inv_reg    <= 1'b0;
            apply_reg  <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            ack_reg    <= 1'b0;
            state_reg  <= OFDC_RUN;
            timer_reg  <= 32'h0000_0000;
        end
        else
        begin
            shadow_reg <= shadow_next;
            active_reg <= active_next;
            inv_reg    <= inv_next;
            apply_reg  <= apply_next;
            rdata_reg  <= rdata_next;
            ack_reg    <= ack_next;
            state_reg  <= state_next;
            timer_reg  <= timer_next;
        end
    end

    assign avs_readdata     = rdata_reg;
    assign avs_waitrequest  = ~ack_reg;
    assign feedback_divider = {active_reg.fb_int, active_reg.fb_frac}; // R02

    // ------------------------------------------------------------------
    // Output divider chain
    // ------------------------------------------------------------------
    logic       hs_clk;
    logic [2:0] ls_eff;
    logic [4:0] ls_cnt_reg, ls_cnt_next;
    logic       ls_bit;
    logic       mute_vco_reg;
    logic [1:0] out_reg, out_next;
    logic       dcc_mode;
    logic [1:0] ext_reg, ext_next;

    ofdc_hs_divider u_hs (
        .clk     (vco_clk),
        .reset   (reset),
        .ratio   (active_reg.hs_div), // R03
        .div_out (hs_clk)
    );

    assign ls_eff = (active_reg.ls_exp > `OFDC_LS_EXP_MAX) ? `OFDC_LS_EXP_MAX
                                                           : active_reg.ls_exp; // R06

    // Binary counter clocked by HS output; bit n divides by 2**(n+1)
    always_comb
    begin
        ls_cnt_next = ls_cnt_reg + 5'h01;
        ls_bit      = (ls_eff == 3'h0) ? hs_clk : ls_cnt_reg[ls_eff - 3'h1]; // R05 R01
        out_next    = {ls_bit ^ inv_reg, ls_bit} & {2{~mute_vco_reg}}; // R08
        dcc_mode    = (ls_eff == 3'h0) && active_reg.hs_div[0] &&
                      (active_reg.hs_div >= `OFDC_HS_DCC_MIN) &&
                      (active_reg.hs_div <= `OFDC_HS_DCC_MAX); // R04
        ext_next    = dcc_mode ? out_reg : {inv_reg, 1'b0};
    end

    always_ff @(posedge hs_clk or posedge reset)
    begin
        if (reset)
            ls_cnt_reg <= 5'h00;
        else
            ls_cnt_reg <= ls_cnt_next;
    end

    always_ff @(posedge vco_clk or posedge reset)
    begin
        if (reset)
        begin
            mute_vco_reg <= 1'b1;
            out_reg      <= 2'b00;
        end
        else
        begin
            mute_vco_reg <= (state_reg == OFDC_MUTE); // R11
            out_reg      <= out_next;
        end
    end

    // Half-cycle stretch for odd ratios needs the falling edge
    always_ff @(negedge vco_clk or posedge reset)
    begin
        if (reset)
            ext_reg <= 2'b00;
        else
            ext_reg <= ext_next;
    end

    // High phase stretched; low phase stretched when inverted
    assign clk_out_a = out_reg[0] | ext_reg[0]; // R04
    assign clk_out_b = inv_reg ? (out_reg[1] & ext_reg[1])
                               : (out_reg[1] | ext_reg[1]); // R08

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_apply_whole: assert property (@(posedge clk) disable iff (reset) // R12
        $changed(active_reg) |-> $past(apply_reg))
        else $error("active set changed without apply");
    chk_mute_entry: assert property (@(posedge clk) disable iff (reset) // R11
        (apply_reg && state_reg == OFDC_RUN && large_change) |=> state_reg == OFDC_MUTE)
        else $error("large change not squelched");
    chk_small_glitch: assert property (@(posedge clk) disable iff (reset) // R10
        (apply_reg && state_reg == OFDC_RUN && !large_change) |=> state_reg == OFDC_SETTLE)
        else $error("small change squelched");
    chk_fb_out: assert property (@(posedge clk) disable iff (reset) // R02
        (apply_reg && state_reg == OFDC_RUN) |=>
            feedback_divider == {$past(shadow_reg.fb_int), $past(shadow_reg.fb_frac)})
        else $error("feedback divider not loaded");
    chk_bus_answer: assert property (@(posedge clk) disable iff (reset) // R09
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    chk_ls_clamp: assert property (@(posedge clk) disable iff (reset) // R06
        (active_reg.ls_exp >= `OFDC_LS_EXP_MAX) |-> (ls_eff == `OFDC_LS_EXP_MAX))
        else $error("low-speed exponent not clamped to five");
    chk_timer_exit: assert property (@(posedge clk) disable iff (reset) // R10
        (state_reg != OFDC_RUN && timer_reg == 32'h0000_0000) |=> state_reg == OFDC_RUN)
        else $error("settle did not end");
    chk_pair_phase: assert property (@(posedge vco_clk) disable iff (reset) // R08
        !inv_reg && $stable(inv_reg) |-> clk_out_a == clk_out_b)
        else $error("in-phase outputs differ");

endmodule // ofdc_top

// *** src/ofdc_defines.svh ***
`ifndef OFDC_DEFINES_SVH
`define OFDC_DEFINES_SVH

// Register byte offsets
`define OFDC_OFF_FB_FRAC     4'h0
`define OFDC_OFF_FB_INT      4'h4
`define OFDC_OFF_HS_DIV      4'h8
`define OFDC_OFF_CTRL        4'hC

// Field positions
`define OFDC_CTRL_LS_LSB     0
`define OFDC_CTRL_LS_MSB     2
`define OFDC_CTRL_APPLY_BIT  3
`define OFDC_CTRL_INV_BIT    4
`define OFDC_CTRL_SQUELCH_BIT 5
`define OFDC_CTRL_BUSY_BIT   8
`define OFDC_CTRL_PEND_BIT   9

// Reset values
`define OFDC_RST_FB_INT      11'h03C
`define OFDC_RST_FB_FRAC     32'h0000_0000
`define OFDC_RST_HS_DIV      11'h008
`define OFDC_RST_LS_EXP      3'h0

// Divider limits
`define OFDC_LS_EXP_MAX      3'h5
`define OFDC_HS_DCC_MIN      11'h005
`define OFDC_HS_DCC_MAX      11'h021

// Timing: 40 MHz clock
`define OFDC_CLK_MHZ         40
`define OFDC_SMALL_SETTLE_US 100
`define OFDC_LARGE_SETTLE_US 10000
`define OFDC_SMALL_CYC       (`OFDC_SMALL_SETTLE_US * `OFDC_CLK_MHZ)
`define OFDC_LARGE_CYC       (`OFDC_LARGE_SETTLE_US * `OFDC_CLK_MHZ)

`endif

// *** src/ofdc_pkg.sv ***
package ofdc_pkg;

    typedef struct packed {
        logic [10:0] fb_int;
        logic [31:0] fb_frac;
        logic [10:0] hs_div;
        logic [2:0]  ls_exp;
    } ofdc_cfg_t;

    typedef enum logic [2:0] {
        OFDC_RUN    = 3'b001,
        OFDC_SETTLE = 3'b010,
        OFDC_MUTE   = 3'b100
    } ofdc_state_t;

endpackage

// *** src/ofdc_hs_divider.sv ***
`timescale 1ns/100ps
`include "ofdc_defines.svh"

// Integer divider with half-cycle duty correction for small odd ratios
module ofdc_hs_divider
    import ofdc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Control
    input  wire logic [10:0] ratio,
    // Divided output
    output logic             div_out
);

    logic [10:0] cnt_reg;
    logic [10:0] cnt_next;
    logic        rise_reg;
    logic        rise_next;
    logic        fall_reg;
    logic        half_reg;
    logic [10:0] high_len;
    logic        dcc;

    always_comb
    begin
        dcc       = ratio[0] && (ratio >= `OFDC_HS_DCC_MIN) && (ratio <= `OFDC_HS_DCC_MAX);
        high_len  = {1'b0, ratio[10:1]};
        cnt_next  = (cnt_reg + 11'h001 >= ratio) ? 11'h000 : cnt_reg + 11'h001;
        rise_next = (cnt_next < high_len);
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_reg  <= 11'h000;
            rise_reg <= 1'b0;
        end
        else
        begin
            cnt_reg  <= cnt_next;
            rise_reg <= rise_next;
        end
    end

    // Half-cycle extension stretches high phase for odd ratios 5..33
    always_ff @(negedge clk or posedge reset)
    begin
        if (reset)
            fall_reg <= 1'b0;
        else
            fall_reg <= rise_reg;
    end

    always_comb
    begin
        half_reg = dcc ? fall_reg : 1'b0;
        div_out  = rise_reg | half_reg; // R04
    end

endmodule // ofdc_hs_divider

// *** testbench/ofdc_host_model.sv ***
`timescale 1ns/100ps

// Register host on the Avalon-MM side
module ofdc_host_model (
    // Bus clock
    input  wire logic        clk,
    // Avalon-MM master
    output logic [3:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    initial
    begin
        avs_address   = 4'h0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // Bus cycle, held until waitrequest is seen low at an edge
    // ------------------------------------------------------------
    task automatic access(input logic is_wr, input logic [3:0] addr,
                          input logic [31:0] wdata, output logic [31:0] rdata);
        @(posedge clk);
        avs_address   <= addr;
        avs_read      <= ~is_wr;
        avs_write     <= is_wr;
        avs_writedata <= wdata;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        rdata = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] addr, input logic [31:0] wdata);
        logic [31:0] unused;
        if (addr != 4'h8 || (wdata >= 32'h0000_0005 && wdata <= 32'h0000_07FE))
            access(1'b1, addr, wdata, unused);
    endtask

    task automatic rd(input logic [3:0] addr, output logic [31:0] rdata);
        access(1'b0, addr, 32'h0000_0000, rdata);
    endtask
endmodule // ofdc_host_model

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps

module tb_top;
    import ofdc_pkg::*;

    logic        clk     = 1'b0;
    logic        reset   = 1'b1;
    logic        vco_clk = 1'b0;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [42:0] feedback_divider;
    logic        clk_out_a;
    logic        clk_out_b;
    logic [31:0] d;
    int          failures   = 0;
    int          num_checks = 0;
    int          hi;
    int          tot;
    int          cfg [4][3] = '{'{5, 0, 1}, '{8, 1, 0}, '{7, 6, 1}, '{33, 7, 0}};

    always #12.5 clk = ~clk;
    always #5 vco_clk = ~vco_clk;

    ofdc_top #(.SMALL_CYC(20), .LARGE_CYC(50)) u_dut (
        .clk(clk), .reset(reset), .vco_clk(vco_clk),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .feedback_divider(feedback_divider),
        .clk_out_a(clk_out_a), .clk_out_b(clk_out_b)
    );

    ofdc_host_model u_host (
        .clk(clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [42:0] seen, input logic [42:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle();
        repeat (40)
        begin
            u_host.rd(4'hC, d);
            if (d[8] === 1'b0)
                break;
        end
    endtask

    // Half-cycles of vco_clk high and in total over one output period
    task automatic measure();
        @(posedge clk_out_a);
        #1;
        hi = 0;
        while (clk_out_a === 1'b1)
        begin
            @(vco_clk);
            #1;
            hi++;
        end
        tot = hi;
        while (clk_out_a === 1'b0)
        begin
            @(vco_clk);
            #1;
            tot++;
        end
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        u_host.rd(4'h0, d);
        check(d, 43'h000_0000_0000);
        u_host.rd(4'h4, d);
        check(d, 43'h000_0000_003C);
        u_host.rd(4'h8, d);
        check(d, 43'h000_0000_0008);
        u_host.rd(4'h2, d);
        check(d, 43'h000_0000_0000);
        check(feedback_divider, 43'h03C_0000_0000);
        u_host.wr(4'h0, 32'h0001_0000);
        u_host.wr(4'h4, 32'h0000_003C);
        u_host.rd(4'hC, d);
        check(d[9], 1'b1);
        check(feedback_divider, 43'h03C_0000_0000);
        u_host.wr(4'hC, 32'h0000_0008);
        u_host.rd(4'hC, d);
        check(d[5], 1'b0);
        settle();
        check(d[8], 1'b0);
        check(feedback_divider, 43'h03C_0001_0000);
        for (int i = 0; i < 4; i++)
        begin
            u_host.wr(4'h8, 32'(cfg[i][0]));
            u_host.wr(4'hC, 32'(cfg[i][1] + 8 + 16 * cfg[i][2]));
            u_host.rd(4'hC, d);
            check(d[5], 1'b1);
            check(clk_out_a, 1'b0);
            settle();
            check(d[8], 1'b0);
            check(d[4:0], 43'(cfg[i][1] + 16 * cfg[i][2]));
            measure();
            measure();
            check(43'(tot), 43'(2 * cfg[i][0] * (1 << ((cfg[i][1] > 5) ? 5 : cfg[i][1]))));
            check(43'(2 * hi), 43'(tot));
            @(posedge clk_out_a);
            #1;
            check(clk_out_b, 43'(cfg[i][2] == 0));
        end
        results();
    end

    initial
    begin
        #500000;
        failures++;
        results();
    end
endmodule // tb_top
